// ===== hw/comparator_control_register.sv
// Control, status and interrupt logic for one op-amp/comparator channel
`timescale 1ns/10ps
module comparator_control_register (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic cmp_raw,
  input wire logic [3:0] input_present,
  output logic unit_enable,
  output logic amp_mode_select,
  output logic [1:0] input_route,
  output logic pin_out,
  output logic pin_out_oe,
  output logic irq
);
  import cmp_ctl_pkg::*;

  logic [15:0] control;
  logic event_flag;
  logic [1:0] status;
  logic [1:0] mask;
  logic sync1, sync2, prev;
  logic compare_result;

  // The analog comparator output is asynchronous to mclk
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= cmp_raw;
      sync2 <= sync1;
      prev <= compare_result;
    end
  end

  // One address comparison shared by the three write decoders
  function automatic logic hit(input logic [1:0] a, input logic [1:0] idx);
    hit = a == idx;
  endfunction
  wire wr_control = wr && hit(addr, ADDR_CONTROL);
  wire wr_status = wr && hit(addr, ADDR_STATUS);
  wire wr_mask = wr && hit(addr, ADDR_MASK);
  wire enable = control[BIT_ENABLE];
  wire amp = control[BIT_AMP_MODE];
  wire [1:0] evpol = control[BIT_EVPOL_HI:BIT_EVPOL_LO];
  wire [1:0] ch = control[BIT_CH_HI:BIT_CH_LO];
  // Unavailable channel selection forces the low-supply route, code 3 reserved for it
  wire ch_ok = CH_PRESENT[ch] && input_present[ch];
  wire [1:0] next_route = ch_ok ? ch : 2'h3;
  // Invert only in comparator mode; a disabled unit reports zero
  wire next_result = enable && !amp && (sync2 ^ control[BIT_INVERT]);
  wire rise = compare_result && !prev;
  wire fall = !compare_result && prev;
  // Polarity code none never matches, so a parked channel stays quiet
  function automatic logic edge_match(input logic [1:0] pol, input logic up, input logic down);
    case (pol)
      EVPOL_RISE: edge_match = up;
      EVPOL_FALL: edge_match = down;
      EVPOL_BOTH: edge_match = up || down;
      default: edge_match = 1'b0;
    endcase
  endfunction
  wire match = edge_match(evpol, rise, fall);
  // While the flag stands, new matches are blocked instead of re-triggering
  wire new_event = match && !event_flag;
  wire blocked = match && event_flag;
  wire clr_flag = wr_control && !wdata[BIT_EVENT];
  // Set wins over a clear in the same cycle, so no event is ever lost
  wire next_flag = match || (event_flag && !clr_flag);
  wire next_pin_oe = enable && !amp && control[BIT_PIN_OE];
  wire [1:0] ev_bits = {blocked, new_event};
  wire [1:0] next_status = ev_bits | (status & ~(wr_status ? wdata[1:0] : 2'h0));
  // Read-only fields are overlaid on the stored writable bits
  wire [15:0] stored_view = control & CONTROL_WMASK & ~(16'h0001 << BIT_EVENT) & ~(16'h0001 << BIT_RESULT);
  wire [15:0] flag_view = 16'(event_flag) << BIT_EVENT;
  wire [15:0] result_view = 16'(compare_result) << BIT_RESULT;
  wire [15:0] ctl_view = stored_view | flag_view | result_view;
  function automatic logic [15:0] read_mux(input logic [1:0] a, input logic [15:0] ctl,
                                           input logic [1:0] st, input logic [1:0] mk);
    case (a)
      ADDR_CONTROL: read_mux = ctl;
      ADDR_STATUS: read_mux = {14'h0000, st};
      ADDR_MASK: read_mux = {14'h0000, mk};
      default: read_mux = 16'h0000;
    endcase
  endfunction
  wire [15:0] next_rdata = rd ? read_mux(addr, ctl_view, status, mask) : 16'h0000;

  // Register bus side: control, mask and read data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      control <= CONTROL_RESET;
    end else if (wr_control) begin
      control <= wdata & CONTROL_WMASK;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask <= 2'h0;
    end else if (wr_mask) begin
      mask <= wdata[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Event side: flag, result and sticky status
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      event_flag <= 1'b0;
      compare_result <= 1'b0;
      status <= 2'h0;
    end else begin
      event_flag <= next_flag;
      compare_result <= next_result;
      status <= next_status;
    end
  end

  // Outputs toward the analog cell, all registered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      unit_enable <= 1'b0;
      amp_mode_select <= 1'b0;
      input_route <= 2'h0;
    end else begin
      unit_enable <= enable;
      amp_mode_select <= amp;
      input_route <= next_route;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_out_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      pin_out <= next_pin_oe && next_result;
      pin_out_oe <= next_pin_oe;
      irq <= |(next_status & mask);
    end
  end

  // Steps of the result path and of register reads
  sequence s_steady_input;
    enable && !amp && $stable(sync2) && $stable(control);
  endsequence

  sequence s_result_settled;
    compare_result == ($past(sync2) ^ $past(control[BIT_INVERT]));
  endsequence

  sequence s_plain_run;
    enable && !amp && !control[BIT_INVERT];
  endsequence

  sequence s_status_read;
    rd && addr == ADDR_STATUS;
  endsequence

  sequence s_ctl_read;
    rd && addr == ADDR_CONTROL;
  endsequence

  // Enable, mode and pin output
  a_enable_mirror: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> unit_enable == $past(enable)) else $error("enable output wrong");

  a_result_zero_off: assert property (@(posedge mclk) disable iff (!rstn)
    !enable |=> !compare_result) else $error("result while disabled");

  a_pin_off_disabled: assert property (@(posedge mclk) disable iff (!rstn)
    !enable |=> !pin_out_oe) else $error("pin driven while disabled");

  a_pin_needs_enable: assert property (@(posedge mclk) disable iff (!rstn)
    pin_out_oe |-> unit_enable) else $error("pin enable without unit enable");

  a_amp_mirror: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> amp_mode_select == $past(amp)) else $error("mode output wrong");

  a_amp_result_zero: assert property (@(posedge mclk) disable iff (!rstn)
    amp |=> !compare_result) else $error("result in amp mode");

  a_pin_off_amp: assert property (@(posedge mclk) disable iff (!rstn)
    amp_mode_select |-> !pin_out_oe) else $error("pin driven in amp mode");

  a_amp_pin_low: assert property (@(posedge mclk) disable iff (!rstn)
    amp_mode_select |-> !pin_out) else $error("pin high in amp mode");

  a_pin_bit_off: assert property (@(posedge mclk) disable iff (!rstn)
    !control[BIT_PIN_OE] |=> !pin_out_oe) else $error("pin enable without its bit");

  a_pin_enable: assert property (@(posedge mclk) disable iff (!rstn)
    $past(next_pin_oe) |-> pin_out_oe) else $error("pin enable missing");

  a_pin_low_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !pin_out_oe |-> !pin_out) else $error("pin high while not driven");

  a_pin_result: assert property (@(posedge mclk) disable iff (!rstn)
    pin_out_oe |-> pin_out == compare_result) else $error("pin differs from result");

  // Result polarity
  a_invert_result: assert property (@(posedge mclk) disable iff (!rstn)
    s_steady_input |=> s_result_settled) else $error("result polarity wrong");

  a_plain_result: assert property (@(posedge mclk) disable iff (!rstn)
    s_plain_run |=> compare_result == $past(sync2)) else $error("plain result wrong");

  a_inverted_result: assert property (@(posedge mclk) disable iff (!rstn)
    enable && !amp && control[BIT_INVERT] |=> compare_result == !$past(sync2)) else $error("inverted result wrong");

  // Register map
  a_ctl_write_lands: assert property (@(posedge mclk) disable iff (!rstn)
    wr_control |=> control == ($past(wdata) & CONTROL_WMASK)) else $error("control write lost");

  a_ctl_kept: assert property (@(posedge mclk) disable iff (!rstn)
    !wr_control |=> $stable(control)) else $error("control changed without write");

  a_unimpl_stored_zero: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |-> (control & ~CONTROL_WMASK) == 16'h0000) else $error("unimplemented bit stored");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rd) |-> (rdata & 16'h182C) == 16'h0000) else $error("reserved bit read one");

  a_idle_rdata: assert property (@(posedge mclk) disable iff (!rstn)
    !rd |=> rdata == 16'h0000) else $error("read data without strobe");

  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rstn)
    rd && addr == 2'h3 |=> rdata == 16'h0000) else $error("unmapped read not zero");

  a_status_read: assert property (@(posedge mclk) disable iff (!rstn)
    s_status_read |=> rdata == {14'h0000, $past(status)}) else $error("status read wrong");

  a_mask_read: assert property (@(posedge mclk) disable iff (!rstn)
    rd && addr == ADDR_MASK |=> rdata == {14'h0000, $past(mask)}) else $error("mask read wrong");

  a_ctl_flag_read: assert property (@(posedge mclk) disable iff (!rstn)
    s_ctl_read |=> rdata[BIT_EVENT] == $past(event_flag)) else $error("flag read wrong");

  a_ctl_result_read: assert property (@(posedge mclk) disable iff (!rstn)
    s_ctl_read |=> rdata[BIT_RESULT] == $past(compare_result)) else $error("result read wrong");

  a_mask_write: assert property (@(posedge mclk) disable iff (!rstn)
    wr_mask |=> mask == $past(wdata[1:0])) else $error("mask write lost");

  // Events and interrupt
  a_flag_sets: assert property (@(posedge mclk) disable iff (!rstn)
    match |=> event_flag) else $error("event not flagged");

  a_flag_blocks: assert property (@(posedge mclk) disable iff (!rstn)
    event_flag && !clr_flag |=> event_flag) else $error("event flag lost");

  a_no_spurious_flag: assert property (@(posedge mclk) disable iff (!rstn)
    !event_flag && !match |=> !event_flag) else $error("flag set without event");

  a_clear_flag: assert property (@(posedge mclk) disable iff (!rstn)
    event_flag && clr_flag && !match |=> !event_flag) else $error("flag not cleared");

  a_flag_read_only: assert property (@(posedge mclk) disable iff (!rstn)
    wr_control && wdata[BIT_EVENT] && !event_flag && !match |=> !event_flag) else $error("flag set by write");

  a_status_new: assert property (@(posedge mclk) disable iff (!rstn)
    new_event |=> status[0]) else $error("new event not in status");

  a_status_blocked: assert property (@(posedge mclk) disable iff (!rstn)
    blocked |=> status[1]) else $error("blocked event not in status");

  a_status_sticky: assert property (@(posedge mclk) disable iff (!rstn)
    status[0] && !(wr_status && wdata[0]) |=> status[0]) else $error("status bit lost");

  a_status_clears: assert property (@(posedge mclk) disable iff (!rstn)
    wr_status && wdata[0] && !new_event |=> !status[0]) else $error("status bit not cleared");

  a_rise_event: assert property (@(posedge mclk) disable iff (!rstn)
    evpol == EVPOL_RISE && rise |=> event_flag) else $error("rising event missed");

  a_fall_event: assert property (@(posedge mclk) disable iff (!rstn)
    evpol == EVPOL_FALL && fall |=> event_flag) else $error("falling event missed");

  a_both_event: assert property (@(posedge mclk) disable iff (!rstn)
    evpol == EVPOL_BOTH && (rise || fall) |=> event_flag) else $error("edge event missed");

  a_none_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    evpol == EVPOL_NONE |-> !match) else $error("event with polarity none");

  a_masked_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    mask == 2'h0 |=> !irq) else $error("interrupt while masked");

  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> irq == $past(|(next_status & mask))) else $error("interrupt level wrong");

  // Input routing
  a_route_low: assert property (@(posedge mclk) disable iff (!rstn)
    !ch_ok |=> input_route == 2'h3) else $error("missing input not grounded");

  a_route_pass: assert property (@(posedge mclk) disable iff (!rstn)
    ch_ok |=> input_route == $past(ch)) else $error("route differs from channel");
endmodule

// ===== hw/cmp_ctl_pkg.sv
// Constants for the comparator channel control register block
package cmp_ctl_pkg;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam int BIT_ENABLE = 15;
  localparam int BIT_PIN_OE = 14;
  localparam int BIT_INVERT = 13;
  localparam int BIT_AMP_MODE = 10;
  localparam int BIT_EVENT = 9;
  localparam int BIT_RESULT = 8;
  localparam int BIT_EVPOL_HI = 7;
  localparam int BIT_EVPOL_LO = 6;
  localparam int BIT_REF_SEL = 4;
  localparam int BIT_CH_HI = 1;
  localparam int BIT_CH_LO = 0;
  localparam logic [15:0] CONTROL_WMASK = 16'hE6D3;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // Event polarity encodings
  localparam logic [1:0] EVPOL_NONE = 2'h0;
  localparam logic [1:0] EVPOL_RISE = 2'h1;
  localparam logic [1:0] EVPOL_FALL = 2'h2;
  localparam logic [1:0] EVPOL_BOTH = 2'h3;
  // Inverting-input channels present on this variant, one bit per code
  localparam logic [3:0] CH_PRESENT = 4'h7;
  localparam logic [1:0] IRQ_EVENT = 2'h0;
  localparam logic [1:0] IRQ_BLOCKED = 2'h1;
endpackage

// ===== verification/cmp_far_side.sv
// Far-side model: analog inputs of the comparator channel
`timescale 1ns/10ps
module cmp_far_side (
  input wire logic [7:0] vin_p,
  input wire logic [7:0] vin_n,
  output logic cmp_raw,
  output logic [3:0] input_present
);
  import cmp_ctl_pkg::*;
  // Equal levels give a low output, so the raw output is always defined
  assign cmp_raw = vin_p > vin_n;
  assign input_present = CH_PRESENT;
endmodule

// ===== verification/test_comparator_control_register.sv
// Self-checking bench for the comparator control register
`timescale 1ns/10ps
module test_comparator_control_register;
  import cmp_ctl_pkg::*;
  logic mclk = 0, rstn = 0, wr = 0, rd = 0, rd_q = 0, cmp_raw, unit_enable, amp_mode_select, pin_out, pin_out_oe, irq;
  logic [1:0] addr = 0, input_route;
  logic [15:0] wdata = 0, rdata;
  logic [15:0] q[$];
  logic [3:0] input_present;
  logic [7:0] vin_p = 0, vin_n = 0;
  logic [31:0] r;
  int bad_count = 0, n_tests = 0, i;
  initial forever #5 mclk = ~mclk;
  comparator_control_register i_comparator_control_register(.mclk(mclk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_raw(cmp_raw), .input_present(input_present),
    .unit_enable(unit_enable), .amp_mode_select(amp_mode_select), .input_route(input_route),
    .pin_out(pin_out), .pin_out_oe(pin_out_oe), .irq(irq));
  cmp_far_side i_cmp_far_side(.vin_p(vin_p), .vin_n(vin_n), .cmp_raw(cmp_raw), .input_present(input_present));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("%0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_q) chk("rdata", q.pop_front(), rdata);
    rd_q <= rd;
  end
  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge mclk);
    wr <= 0;
    @(posedge mclk);
  endtask
  task automatic rreg(input logic [1:0] a, input logic [15:0] e);
    q.push_back(e);
    addr <= a;
    rd <= 1;
    @(posedge mclk);
    rd <= 0;
    @(posedge mclk);
  endtask
  task automatic wait_irq(input logic e);
    for (int k = 0; k < 8 && irq !== e; k++) @(posedge mclk);
    chk("irq", {15'h0, e}, {15'h0, irq});
    if (irq !== e) final_report;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report;
  end
  initial begin
    void'($urandom(5513));
    repeat (16) @(posedge mclk);
    rstn <= 1;
    @(posedge mclk);
    chk("outs", 16'h0, {12'h0, unit_enable, pin_out, pin_out_oe, irq});
    for (i = 0; i < 4; i++) rreg(i[1:0], 16'h0000);
    wreg(ADDR_CONTROL, 16'hFFFF);
    repeat (2) @(posedge mclk);
    chk("route", 16'h0003, {14'h0, input_route});
    chk("mode", 16'h0005, {13'h0, unit_enable, pin_out_oe, amp_mode_select});
    rreg(ADDR_CONTROL, 16'hE4D3);
    $display("test register map done");
    vin_p <= 8'h0A;
    wreg(ADDR_CONTROL, 16'hC041);
    repeat (6) @(posedge mclk);
    chk("pin", 16'h0007, {13'h0, pin_out, pin_out_oe, input_route == 2'h1});
    rreg(ADDR_CONTROL, 16'hC341);
    rreg(ADDR_STATUS, 16'h0001);
    chk("irq", 16'h0, {15'h0, irq});
    wreg(ADDR_MASK, 16'h0001);
    wait_irq(1);
    wreg(ADDR_STATUS, 16'h0001);
    wait_irq(0);
    vin_p <= 8'h00;
    repeat (6) @(posedge mclk);
    vin_p <= 8'h0A;
    repeat (6) @(posedge mclk);
    rreg(ADDR_STATUS, 16'h0002);
    wreg(ADDR_CONTROL, 16'hC041);
    rreg(ADDR_CONTROL, 16'hC141);
    wreg(ADDR_STATUS, 16'h0002);
    $display("test events done");
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      vin_p <= {r[7:1], 1'b1};
      vin_n <= {r[15:9], 1'b0};
      wreg(ADDR_CONTROL, {2'b10, r[16], 13'h0001});
      repeat (5) @(posedge mclk);
      rreg(ADDR_CONTROL, {2'b10, r[16], 4'h0, (r[7:1] >= r[15:9]) ^ r[16], 8'h01});
    end
    $display("test polarity done");
    final_report;
  end
endmodule
